// file: bsfc_pkg.sv
// Contract
// - Chip select, write strobe and output strobe are separate active-low controls.
// - Commands are ordinary write cycles into the device command register.
// - Bypass mode programs with two writes instead of four.
// - Erase may be suspended any time, then resumed by the host.
// - Host may put device in standby through its control inputs.
`default_nettype none
package bsfc_pkg;
   // ==========================================================
   // Register map of the controller (Avalon-MM word offsets)
   localparam logic [3:0] BSFC_REG_CTRL   = 4'h0;
   localparam logic [3:0] BSFC_REG_ADDR   = 4'h1;
   localparam logic [3:0] BSFC_REG_WDATA  = 4'h2;
   localparam logic [3:0] BSFC_REG_RDATA  = 4'h3;
   localparam logic [3:0] BSFC_REG_STATUS = 4'h4;
   localparam logic [3:0] BSFC_REG_SEQA   = 4'h5;
   localparam logic [3:0] BSFC_REG_SEQD   = 4'h6;
   // Control field positions
   localparam int BSFC_CTRL_GO      = 0;
   localparam int BSFC_CTRL_WRITE   = 1;
   localparam int BSFC_CTRL_WORD    = 2;
   localparam int BSFC_CTRL_RESET   = 3;
   localparam int BSFC_CTRL_STANDBY = 4;
   localparam int BSFC_CTRL_POLL    = 5;
   localparam int BSFC_CTRL_LENLO   = 8;
   localparam int BSFC_CTRL_LENHI   = 10;
   // Status field positions
   localparam int BSFC_ST_BUSY      = 0;
   localparam int BSFC_ST_READY     = 1;
   localparam int BSFC_ST_POLLBIT   = 2;
   localparam int BSFC_ST_TOGGLE    = 3;
   localparam int BSFC_ST_WORD      = 4;
   localparam int BSFC_ST_POLLDONE  = 5;
   // Status bits on the data lines
   localparam int BSFC_POLL_BIT     = 7;
   localparam int BSFC_TOGGLE_BIT   = 6;
   // Bus geometry
   localparam int BSFC_ADDR_W       = 21;
   localparam int BSFC_DATA_W       = 16;
   localparam int BSFC_BYTE_W       = 8;
   localparam int BSFC_SEQ_MAX      = 4;
   localparam logic [20:0] BSFC_BYTE_SPACE = 21'h1fffff;
   localparam logic [20:0] BSFC_WORD_SPACE = 21'h0fffff;
   // Timing
   localparam int BSFC_CLK_NS       = 10;
   localparam int BSFC_ACCESS_NS    = 120;
   localparam int BSFC_WRPULSE_NS   = 50;
   localparam int BSFC_RESET_NS     = 500;
   localparam int BSFC_ACCESS_CYC   = (BSFC_ACCESS_NS + BSFC_CLK_NS - 1) / BSFC_CLK_NS;
   localparam int BSFC_WRPULSE_CYC  = (BSFC_WRPULSE_NS + BSFC_CLK_NS - 1) / BSFC_CLK_NS;
   localparam int BSFC_RESET_CYC    = (BSFC_RESET_NS + BSFC_CLK_NS - 1) / BSFC_CLK_NS;
   localparam int BSFC_CNT_W        = 8;
   // Bus cycle sequencer states
   typedef enum logic [2:0] {
      BSFC_IDLE, BSFC_SETUP, BSFC_WPULSE, BSFC_RPULSE, BSFC_HOLD, BSFC_RST
   } bsfc_state_t;
endpackage
`default_nettype wire

// file: bsfc_counter.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Loadable down counter used for pulse timing
module bsfc_counter
   import bsfc_pkg::*;
(
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   // Control
   input  wire logic                  load,
   input  wire logic [BSFC_CNT_W-1:0] loadValue,
   // Result
   output logic                       done
);
   logic [BSFC_CNT_W-1:0] count;

   // Load N gives done N cycles later, so a timed state lasts exactly N cycles
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (load) begin
         count <= loadValue - 1'b1; // Callers never load zero
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   // Done from the count alone: gating it with load would loop through the caller
   assign done = (count == '0);
endmodule // bsfc_counter
`default_nettype wire

// file: bsfc_host.sv
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Host controller driving a parallel flash through its pins
module bsfc_host
   import bsfc_pkg::*;
(
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   // Avalon-MM slave
   input  wire logic [3:0]             avsAddress,
   input  wire logic                   avsRead,
   input  wire logic                   avsWrite,
   input  wire logic [31:0]            avsWriteData,
   output logic      [31:0]            avsReadData,
   output logic                        avsWaitRequest,
   // Flash pins
   output logic      [BSFC_ADDR_W-1:0] flashAddr,
   input  wire logic [BSFC_DATA_W-1:0] dataLinesIn,
   output logic      [BSFC_DATA_W-1:0] dataLinesOut,
   output logic                        dataLinesOe,
   output logic                        chipSelect_n,
   output logic                        writeStrobe_n,
   output logic                        outputStrobe_n,
   output logic                        wordMode_n,
   output logic                        hwReset_n,
   input  wire logic                   ready_busy_out_n
);
   bsfc_state_t state;
   logic [10:0] ctrl;
   logic [BSFC_ADDR_W-1:0] addrReg;
   logic [BSFC_DATA_W-1:0] wdataReg;
   logic [BSFC_DATA_W-1:0] rdataReg;
   logic [BSFC_ADDR_W-1:0] seqAddr [BSFC_SEQ_MAX];
   logic [BSFC_DATA_W-1:0] seqData [BSFC_SEQ_MAX];
   logic [1:0] seqIdx;
   logic [1:0] seqLen;
   logic       busy;
   logic       pollDone;
   logic       lastToggle;
   logic       toggleSeen;
   logic       cntLoad;
   logic [BSFC_CNT_W-1:0] cntValue;
   logic       cntDone;
   logic       goWrite;
   logic       regWrite;
   logic [BSFC_DATA_W-1:0] rxData;

   bsfc_counter u_timer (
      .clock     (clock),
      .rst_n     (rst_n),
      .load      (cntLoad),
      .loadValue (cntValue),
      .done      (cntDone)
   );

   // ==========================================================
   // Register slave: zero wait states, waitrequest only on go while busy
   assign regWrite = avsWrite && !(busy && avsAddress == BSFC_REG_CTRL
                                   && avsWriteData[BSFC_CTRL_GO]);
   assign avsWaitRequest = avsWrite && !regWrite;
   assign goWrite  = regWrite && avsAddress == BSFC_REG_CTRL && avsWriteData[BSFC_CTRL_GO];

   // Control and data registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl     <= '0;
         addrReg  <= '0;
         wdataReg <= '0;
      end else if (regWrite) begin
         case (avsAddress)
            BSFC_REG_CTRL:  ctrl     <= {avsWriteData[10:1], 1'b0};
            BSFC_REG_ADDR:  addrReg  <= avsWriteData[BSFC_ADDR_W-1:0];
            BSFC_REG_WDATA: wdataReg <= avsWriteData[BSFC_DATA_W-1:0];
            default: ;
         endcase
      end
   end

   // Command sequence table; bypass programming just uses a length of one
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < BSFC_SEQ_MAX; i++) begin
            seqAddr[i] <= '0;
            seqData[i] <= '0;
         end
      end else if (regWrite && avsAddress == BSFC_REG_SEQA) begin
         seqAddr[avsWriteData[29:28]] <= avsWriteData[BSFC_ADDR_W-1:0];
      end else if (regWrite && avsAddress == BSFC_REG_SEQD) begin
         seqData[avsWriteData[29:28]] <= avsWriteData[BSFC_DATA_W-1:0];
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      avsReadData = '0;
      case (avsAddress)
         BSFC_REG_CTRL:   avsReadData[10:0] = ctrl;
         BSFC_REG_ADDR:   avsReadData[BSFC_ADDR_W-1:0] = addrReg;
         BSFC_REG_WDATA:  avsReadData[BSFC_DATA_W-1:0] = wdataReg;
         BSFC_REG_RDATA:  avsReadData[BSFC_DATA_W-1:0] = rdataReg;
         BSFC_REG_STATUS: begin
            avsReadData[BSFC_ST_BUSY]     = busy;
            avsReadData[BSFC_ST_READY]    = ready_busy_out_n;
            avsReadData[BSFC_ST_POLLBIT]  = rdataReg[BSFC_POLL_BIT];
            avsReadData[BSFC_ST_TOGGLE]   = toggleSeen;
            avsReadData[BSFC_ST_WORD]     = ctrl[BSFC_CTRL_WORD];
            avsReadData[BSFC_ST_POLLDONE] = pollDone;
         end
         default: ;
      endcase
   end

   // ==========================================================
   // Pin sequencer
   assign busy = (state != BSFC_IDLE);

   // Byte mode only samples the low eight lines; writes still drive all sixteen
   assign rxData = ctrl[BSFC_CTRL_WORD] ? dataLinesIn
                 : {{(BSFC_DATA_W-BSFC_BYTE_W){1'b0}}, dataLinesIn[BSFC_BYTE_W-1:0]};

   always_comb begin
      cntLoad  = 1'b0;
      cntValue = '0;
      case (state)
         BSFC_IDLE: begin
            cntLoad  = goWrite;
            cntValue = avsWriteData[BSFC_CTRL_RESET]
                     ? BSFC_CNT_W'(BSFC_RESET_CYC) : BSFC_CNT_W'(1);
         end
         BSFC_SETUP: begin
            cntLoad  = cntDone;
            cntValue = ctrl[BSFC_CTRL_WRITE] ? BSFC_CNT_W'(BSFC_WRPULSE_CYC)
                                             : BSFC_CNT_W'(BSFC_ACCESS_CYC);
         end
         BSFC_WPULSE, BSFC_RPULSE: begin
            cntLoad  = cntDone;
            cntValue = BSFC_CNT_W'(1);
         end
         default: ;
      endcase
   end

   // Sequencer state and pins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state          <= BSFC_IDLE;
         seqIdx         <= '0;
         seqLen         <= '0;
         flashAddr      <= '0;
         dataLinesOut   <= '0;
         dataLinesOe    <= 1'b0;
         chipSelect_n   <= 1'b1;
         writeStrobe_n  <= 1'b1;
         outputStrobe_n <= 1'b1;
         hwReset_n      <= 1'b1;
      end else begin
         case (state)
            BSFC_IDLE: begin
               if (goWrite) begin
                  seqIdx <= '0;
                  seqLen <= avsWriteData[BSFC_CTRL_LENLO+1:BSFC_CTRL_LENLO];
                  if (avsWriteData[BSFC_CTRL_RESET]) begin
                     hwReset_n <= 1'b0;
                     state     <= BSFC_RST;
                  end else begin
                     chipSelect_n <= 1'b0;
                     flashAddr    <= (avsWriteData[BSFC_CTRL_WRITE] &&
                                      avsWriteData[BSFC_CTRL_LENLO+1:BSFC_CTRL_LENLO] != 2'h0)
                                   ? seqAddr[0] : addrReg;
                     state        <= BSFC_SETUP;
                  end
               end else begin
                  chipSelect_n <= ctrl[BSFC_CTRL_STANDBY] ? 1'b1 : chipSelect_n;
               end
            end
            BSFC_SETUP: begin
               if (cntDone) begin
                  if (ctrl[BSFC_CTRL_WRITE]) begin
                     // Command write: device latches address and data
                     dataLinesOe   <= 1'b1;
                     dataLinesOut  <= (seqLen != 2'h0 && seqIdx != seqLen) ?
                                      seqData[seqIdx] : wdataReg;
                     writeStrobe_n <= 1'b0;
                     state         <= BSFC_WPULSE;
                  end else begin
                     dataLinesOe    <= 1'b0; // Release bus before strobe: no contention
                     outputStrobe_n <= 1'b0;
                     state          <= BSFC_RPULSE;
                  end
               end
            end
            BSFC_WPULSE: begin
               if (cntDone) begin
                  writeStrobe_n <= 1'b1;
                  state         <= BSFC_HOLD;
               end
            end
            BSFC_RPULSE: begin
               if (cntDone) begin
                  outputStrobe_n <= 1'b1;
                  state          <= BSFC_HOLD;
               end
            end
            BSFC_HOLD: begin
               dataLinesOe <= 1'b0;
               if (ctrl[BSFC_CTRL_WRITE] && seqLen != 2'h0 && seqIdx != seqLen) begin
                  // Next cycle of a multi-write command sequence
                  seqIdx    <= seqIdx + 1'b1;
                  flashAddr <= (seqIdx + 1'b1 == seqLen) ? addrReg : seqAddr[seqIdx + 1'b1];
                  state     <= BSFC_SETUP;
               end else begin
                  chipSelect_n <= 1'b1;
                  state        <= BSFC_IDLE;
               end
            end
            BSFC_RST: begin
               if (cntDone) begin
                  hwReset_n <= 1'b1;
                  state     <= BSFC_IDLE;
               end
            end
            default: state <= BSFC_IDLE;
         endcase
      end
   end

   // Read capture and toggle-bit polling
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdataReg   <= '0;
         lastToggle <= 1'b0;
         toggleSeen <= 1'b0;
         pollDone   <= 1'b0;
      end else if (state == BSFC_RPULSE && cntDone) begin
         rdataReg   <= rxData;
         lastToggle <= rxData[BSFC_TOGGLE_BIT];
         if (ctrl[BSFC_CTRL_POLL]) begin
            toggleSeen <= rxData[BSFC_TOGGLE_BIT] ^ lastToggle;
            pollDone   <= !(rxData[BSFC_TOGGLE_BIT] ^ lastToggle);
         end
      end
   end

   assign wordMode_n = ctrl[BSFC_CTRL_WORD]; // High selects sixteen-bit mode
endmodule // bsfc_host
`default_nettype wire

// file: bsfc_host_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Pin-level checks of the flash host
module bsfc_host_properties
   import bsfc_pkg::*;
(
   // Clock and reset
   input wire logic                   clock,
   input wire logic                   rst_n,
   // Avalon-MM side
   input wire logic [3:0]             avsAddress,
   input wire logic                   avsWrite,
   input wire logic [31:0]            avsWriteData,
   input wire logic                   avsWaitRequest,
   // Flash pins
   input wire logic [BSFC_ADDR_W-1:0] flashAddr,
   input wire logic [BSFC_DATA_W-1:0] dataLinesOut,
   input wire logic                   dataLinesOe,
   input wire logic                   chipSelect_n,
   input wire logic                   writeStrobe_n,
   input wire logic                   outputStrobe_n,
   input wire logic                   hwReset_n
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Strobes never overlap, so the data bus has one owner
   AST_STROBE_EXCL: assert property (writeStrobe_n || outputStrobe_n)
      else $error("both strobes low");
   AST_WE_IN_CS: assert property (!writeStrobe_n |-> !chipSelect_n)
      else $error("write strobe without select");
   AST_OE_IN_CS: assert property (!outputStrobe_n |-> !chipSelect_n)
      else $error("output strobe without select");
   AST_DRIVE_ON_WE: assert property (!writeStrobe_n |-> dataLinesOe)
      else $error("write strobe with lines released");
   AST_FREE_ON_OE: assert property (!outputStrobe_n |-> !dataLinesOe)
      else $error("lines driven during read");
   AST_WE_WIDTH: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n[*5] ##1 writeStrobe_n)
      else $error("write pulse width wrong");
   // Device latches on the strobe edge, so nothing may move under it
   AST_LATCH_STABLE: assert property (!writeStrobe_n |=> writeStrobe_n ||
      ($stable(flashAddr) && $stable(dataLinesOut)))
      else $error("address or data moved in write pulse");
   AST_RD_WIDTH: assert property ($fell(outputStrobe_n) |->
      !outputStrobe_n[*8] ##4 !outputStrobe_n ##1 outputStrobe_n)
      else $error("read pulse width wrong");
   AST_RESET_WIDTH: assert property ($fell(hwReset_n) |-> ##49 !hwReset_n ##1 hwReset_n)
      else $error("reset pulse width wrong");
   // A stall is only legal while a cycle or the reset pulse is on the pins
   AST_WAIT_CAUSE: assert property (avsWaitRequest |->
      avsWrite && avsAddress == BSFC_REG_CTRL && avsWriteData[BSFC_CTRL_GO]
      && (!chipSelect_n || !hwReset_n))
      else $error("stall without a go request");
   // Main scenarios reached
   cover property ($fell(writeStrobe_n));
   cover property ($fell(outputStrobe_n));
   cover property ($fell(hwReset_n));
   cover property (avsWaitRequest);
endmodule // bsfc_host_properties

bind bsfc_host bsfc_host_properties checker_i (.clock(clock), .rst_n(rst_n),
   .avsAddress(avsAddress), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
   .avsWaitRequest(avsWaitRequest), .flashAddr(flashAddr), .dataLinesOut(dataLinesOut),
   .dataLinesOe(dataLinesOe), .chipSelect_n(chipSelect_n), .writeStrobe_n(writeStrobe_n),
   .outputStrobe_n(outputStrobe_n), .hwReset_n(hwReset_n));
`default_nettype wire

// file: bsfc_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Behavioural parallel flash, small array, one program command
module bsfc_flash_model
   import bsfc_pkg::*;
#(
   parameter logic [7:0] PROG_CODE = 8'h5a, // Arbitrary arming code
   parameter int         BUSY_CYC  = 40
)
(
   // Clock for the busy timer and the released-line pattern
   input  wire logic                   clock,
   // Pins from the host
   input  wire logic [BSFC_ADDR_W-1:0] flashAddr,
   input  wire logic [BSFC_DATA_W-1:0] dataLinesOut,
   input  wire logic                   dataLinesOe,
   input  wire logic                   chipSelect_n,
   input  wire logic                   writeStrobe_n,
   input  wire logic                   outputStrobe_n,
   input  wire logic                   wordMode_n,
   input  wire logic                   hwReset_n,
   // Pins to the host
   output logic      [BSFC_DATA_W-1:0] dataLinesIn,
   output logic                        ready_busy_out_n
);
   logic [15:0] mem [256];
   logic [15:0] pd, rdVal, last;
   logic [7:0]  pa;
   logic        armed, tog;
   int          busyCnt;
   initial begin
      foreach (mem[i]) mem[i] = 16'h0;
      {armed, tog, busyCnt, last, pd, pa} = '0;
   end
   // Commands latched on the rising write strobe; ignored while busy
   always @(posedge writeStrobe_n) if (!chipSelect_n && hwReset_n && busyCnt == 0) begin
      if (armed) begin
         pa      <= flashAddr[7:0];
         pd      <= wordMode_n ? dataLinesOut : {8'h00, dataLinesOut[7:0]};
         busyCnt <= BUSY_CYC;
      end
      armed <= !armed && dataLinesOut[7:0] == PROG_CODE;
   end
   // Self-timed program; reset pin aborts and drops the data
   always @(posedge clock) begin
      last <= dataLinesIn;
      if (!hwReset_n) {busyCnt, armed} <= '0;
      else if (busyCnt == 1) begin
         mem[pa] <= pd;
         busyCnt <= 0;
      end else if (busyCnt > 1) busyCnt <= busyCnt - 1;
   end
   always @(negedge outputStrobe_n) tog <= ~tog;
   assign ready_busy_out_n = busyCnt == 0;
   assign rdVal = busyCnt != 0 ? {8'h00, ~pd[7], tog, 6'h00} : mem[flashAddr[7:0]];
   // Released lines show a changing pattern, never a held value
   assign dataLinesIn = dataLinesOe ? dataLinesOut :
      (!chipSelect_n && !outputStrobe_n) ?
      (wordMode_n ? rdVal : {~last[15:8], rdVal[7:0]}) : ~last;
endmodule // bsfc_flash_model
`default_nettype wire

// file: boot_sector_flash_command_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module boot_sector_flash_command_control_test
   import bsfc_pkg::*;
;
   logic        clock, rst_n, avsRead, avsWrite, avsWaitRequest;
   logic [3:0]  avsAddress;
   logic [31:0] avsWriteData, avsReadData, r;
   logic [20:0] flashAddr;
   logic [15:0] dataLinesIn, dataLinesOut;
   logic        dataLinesOe, chipSelect_n, writeStrobe_n, outputStrobe_n;
   logic        wordMode_n, hwReset_n, ready_busy_out_n;
   int          mismatches, n_compared;
   // Rows: word mode, address, data
   logic [37:0] rows [4] = '{{1'b1, 21'h10, 16'h1234}, {1'b1, 21'hff, 16'h8001},
                             {1'b0, 21'h20, 16'h00a5}, {1'b0, 21'h21, 16'h007e}};
   bsfc_host dut (.clock(clock), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .flashAddr(flashAddr), .dataLinesIn(dataLinesIn),
      .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe), .chipSelect_n(chipSelect_n),
      .writeStrobe_n(writeStrobe_n), .outputStrobe_n(outputStrobe_n),
      .wordMode_n(wordMode_n), .hwReset_n(hwReset_n), .ready_busy_out_n(ready_busy_out_n));
   bsfc_flash_model flash (.clock(clock), .flashAddr(flashAddr), .dataLinesOut(dataLinesOut),
      .dataLinesOe(dataLinesOe), .chipSelect_n(chipSelect_n), .writeStrobe_n(writeStrobe_n),
      .outputStrobe_n(outputStrobe_n), .wordMode_n(wordMode_n), .hwReset_n(hwReset_n),
      .dataLinesIn(dataLinesIn), .ready_busy_out_n(ready_busy_out_n));
   // ==========================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One Avalon cycle; a spare edge keeps requests apart
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= wr;
      avsRead <= !wr;
      do @(posedge clock); while (avsWaitRequest !== 1'b0);
      r = avsReadData;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge clock);
   endtask
   // Idle means host done and ready pin high; running out of polls fails the run
   task automatic waitIdle;
      int k;
      for (k = 0; k < 400; k++) begin
         bus(1'b0, BSFC_REG_STATUS, 32'h0);
         if (r[BSFC_ST_BUSY] === 1'b0 && r[BSFC_ST_READY] === 1'b1) break;
      end
      if (k == 400) begin
         mismatches++;
         end_sim();
      end
   endtask
   task automatic prog(input logic [20:0] a, input logic [15:0] d, input logic w);
      bus(1'b1, BSFC_REG_ADDR, {11'h0, a});
      bus(1'b1, BSFC_REG_WDATA, {16'h0, d});
      bus(1'b1, BSFC_REG_SEQA, 32'h0);
      bus(1'b1, BSFC_REG_SEQD, 32'h5a);
      bus(1'b1, BSFC_REG_CTRL, 32'h103 | {29'h0, w, 2'b00});
   endtask
   task automatic rdFlash(input logic [20:0] a, input logic w);
      bus(1'b1, BSFC_REG_ADDR, {11'h0, a});
      bus(1'b1, BSFC_REG_CTRL, 32'h1 | {29'h0, w, 2'b00});
      waitIdle();
      bus(1'b0, BSFC_REG_RDATA, 32'h0);
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Watchdog well beyond the expected run
   initial begin
      #500000;
      mismatches++;
      end_sim();
   end
   // ==========================================================
   // Main sequence
   initial begin
      {rst_n, avsRead, avsWrite, avsAddress, avsWriteData} = '0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      bus(1'b0, BSFC_REG_CTRL, 32'h0);
      chk(r, 32'h0);
      bus(1'b0, BSFC_REG_STATUS, 32'h0);
      chk(r & 32'h3, 32'h2);
      foreach (rows[i]) begin
         prog(rows[i][36:16], rows[i][15:0], rows[i][37]);
         waitIdle();
         rdFlash(rows[i][36:16], rows[i][37]);
         chk(r, rows[i][37] ? {16'h0, rows[i][15:0]} : {24'h0, rows[i][7:0]});
      end
      // Read issued at once: stalls, then sees status
      prog(21'h30, 16'h0055, 1'b1);
      rdFlash(21'h30, 1'b1);
      chk(r & 32'hff80, 32'h80);
      rdFlash(21'h30, 1'b1);
      chk(r, 32'h55);
      // Toggle polling: two busy polls differ, two idle polls agree
      prog(21'h38, 16'h0077, 1'b1);
      repeat (2) bus(1'b1, BSFC_REG_CTRL, 32'h25);
      waitIdle();
      bus(1'b0, BSFC_REG_STATUS, 32'h0);
      chk(r & 32'h28, 32'h08);
      repeat (2) bus(1'b1, BSFC_REG_CTRL, 32'h25);
      waitIdle();
      bus(1'b0, BSFC_REG_STATUS, 32'h0);
      chk(r & 32'h2c, 32'h20);
      // Reset pin in mid-program leaves the location unwritten
      prog(21'h28, 16'h1111, 1'b1);
      bus(1'b1, BSFC_REG_CTRL, 32'hd);
      waitIdle();
      rdFlash(21'h28, 1'b1);
      chk(r, 32'h0);
      bus(1'b1, 4'hf, 32'hffffffff);
      bus(1'b0, 4'hf, 32'h0);
      chk(r, 32'h0);
      bus(1'b1, BSFC_REG_CTRL, 32'h10);
      repeat (4) @(posedge clock);
      chk({31'h0, chipSelect_n}, 32'h1);
      bus(1'b0, BSFC_REG_CTRL, 32'h0);
      chk(r, 32'h10);
      end_sim();
   end
endmodule // boot_sector_flash_command_control_test
`default_nettype wire
